// ==== rtl/dmap_top.sv ====
// dma map translation and interrupt service registers behind apb
`timescale 1ns/100ps
module dmap_top
  import dmap_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic DMA_START,
  input wire logic DMA_FIN,
  input wire logic DMA_REQ,
  input wire logic [23:0] DMA_ADDR,
  input wire logic [1:0] DMA_SIZE,
  input wire logic [31:0] DMA_DATA,
  output logic HOST_VALID,
  output logic [31:0] HOST_ADDR,
  output logic [31:0] HOST_DATA,
  output logic HOST_TIMEOUT,
  input wire logic [3:0] ERR_EV,
  input wire logic PR_EV,
  input wire logic PT_EV,
  input wire logic [7:1] IRQ_LVL,
  input wire logic REM_REQ,
  output logic REM_GNT,
  output logic IRQ
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [7:1] lvl_meta_q;
  logic [7:1] lvl_sync_q;
  logic [7:1] lvl_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic map_pend_q;
  logic norm_en_q;
  logic err_en_q;
  logic [3:0] err_q;
  logic pr_q;
  logic pt_q;
  logic busy_q;
  logic done_q;
  logic done_ien_q;
  logic irq_q;
  logic rem_gnt_q;
  logic v1_q;
  logic [11:0] off1_q;
  logic [1:0] size1_q;
  logic [31:0] data1_q;
  logic host_valid_q;
  logic [31:0] host_addr_q;
  logic [31:0] host_data_q;
  logic host_tmo_q;
  logic acc;
  logic fin;
  logic is_map;
  logic known;
  logic wr_fin;
  logic [31:0] reg_rdata;
  logic irq_d;

  dmap_map_if mp ();

  dmap_map_ram dmap_map_ram_inst (
    .clk(CLK),
    .mp(mp.mem)
  );

  // byte swap for non-byte beats
  function automatic logic [31:0] swap_beat(input logic [31:0] d,
                                            input logic [1:0] sz);
    logic [31:0] r;
    r = d;
    if (sz == DMAP_SZ_WORD) begin
      r = {d[23:16], d[31:24], d[7:0], d[15:8]};
    end else if (sz != DMAP_SZ_BYTE) begin
      r = {d[7:0], d[15:8], d[23:16], d[31:24]};
    end
    return r;
  endfunction

  // reset release
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // backplane level synchroniser
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      lvl_meta_q <= DMAP_LVL_RST;
      lvl_sync_q <= DMAP_LVL_RST;
    end else begin
      lvl_meta_q <= IRQ_LVL;
      lvl_sync_q <= lvl_meta_q;
    end
  end

  // apb decode
  assign acc = PSEL & PENABLE;
  assign fin = acc & pready_q;
  assign wr_fin = fin & PWRITE;
  assign is_map = (PADDR >= DMAP_OFS_MAP_BASE);

  always_comb begin
    reg_rdata = 32'h0;
    known = 1'b1;
    case (PADDR)
      DMAP_OFS_IRQ_CTRL: begin
        reg_rdata[DMAP_BIT_ACTIVE] = irq_q;
        reg_rdata[DMAP_BIT_NORM_EN] = norm_en_q;
        reg_rdata[DMAP_BIT_ERR_EN] = err_en_q;
      end
      DMAP_OFS_LOC_STAT: begin
        reg_rdata[3:0] = err_q;
        reg_rdata[DMAP_BIT_PR] = pr_q;
      end
      DMAP_OFS_LOC_CMD: reg_rdata = 32'h0;
      DMAP_OFS_DMA_CMD: begin
        reg_rdata[DMAP_BIT_START] = busy_q;
        reg_rdata[DMAP_BIT_DONE] = done_q;
        reg_rdata[DMAP_BIT_DONE_IEN] = done_ien_q;
      end
      DMAP_OFS_REM_STAT: reg_rdata[DMAP_BIT_PT] = pt_q;
      DMAP_OFS_REM_CMD1: reg_rdata = 32'h0;
      DMAP_OFS_LVL_STAT: reg_rdata[7:1] = lvl_q;
      default: known = is_map;
    endcase
  end

  // mapping store ports
  assign mp.we = wr_fin & is_map;
  assign mp.waddr = PADDR[13:2];
  assign mp.wdata = PWDATA;
  assign mp.ra_addr = PADDR[13:2];
  assign mp.rb_addr = DMA_ADDR[23:12];

  // apb answer
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
      map_pend_q <= 1'b0;
    end else if (pready_q) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      map_pend_q <= 1'b0;
    end else if (acc & is_map & !PWRITE & !map_pend_q) begin
      map_pend_q <= 1'b1;
    end else if (acc & map_pend_q) begin
      pready_q <= 1'b1;
      prdata_q <= mp.ra_data;
    end else if (acc) begin
      pready_q <= 1'b1;
      pslverr_q <= !known;
      prdata_q <= PWRITE ? 32'h0 : reg_rdata;
    end
  end

  // interrupt control enables
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      norm_en_q <= 1'b0;
      err_en_q <= 1'b0;
    end else if (wr_fin && PADDR == DMAP_OFS_IRQ_CTRL) begin
      norm_en_q <= PWDATA[DMAP_BIT_NORM_EN];
      err_en_q <= PWDATA[DMAP_BIT_ERR_EN];
    end
  end

  // error status, new errors win over a clear
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= DMAP_ERR_RST;
    end else if (wr_fin && PADDR == DMAP_OFS_LOC_CMD
                 && PWDATA[DMAP_BIT_CLR_ERR]) begin
      err_q <= ERR_EV;
    end else begin
      err_q <= err_q | ERR_EV;
    end
  end

  // programmed interrupts from the far side, events dropped while a dma runs
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pr_q <= 1'b0;
    end else if (PR_EV & !busy_q) begin
      pr_q <= 1'b1;
    end else if (wr_fin && PADDR == DMAP_OFS_LOC_CMD
                 && PWDATA[DMAP_BIT_CLR_IRQ]) begin
      pr_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pt_q <= 1'b0;
    end else if (PT_EV & !busy_q) begin
      pt_q <= 1'b1;
    end else if (wr_fin && PADDR == DMAP_OFS_REM_CMD1
                 && PWDATA[DMAP_BIT_CLR_IRQ]) begin
      pt_q <= 1'b0;
    end
  end

  // backplane levels, frozen while a dma runs
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      lvl_q <= DMAP_LVL_RST;
    end else if (!busy_q) begin
      lvl_q <= lvl_sync_q;
    end
  end

  // dma command: start, done, done interrupt enable
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else if (busy_q & DMA_FIN) begin
      busy_q <= 1'b0;
    end else if (wr_fin && PADDR == DMAP_OFS_DMA_CMD
                 && PWDATA[DMAP_BIT_START]) begin
      busy_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else if (busy_q & DMA_FIN) begin
      done_q <= 1'b1;
    end else if (wr_fin && PADDR == DMAP_OFS_DMA_CMD
                 && !PWDATA[DMAP_BIT_DONE]) begin
      done_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      done_ien_q <= 1'b0;
    end else if (wr_fin && PADDR == DMAP_OFS_DMA_CMD) begin
      done_ien_q <= PWDATA[DMAP_BIT_DONE_IEN];
    end
  end

  // interrupt line
  always_comb begin
    irq_d = err_en_q & (|err_q);
    if (norm_en_q) begin
      irq_d = irq_d | (done_q & done_ien_q);
      irq_d = irq_d | (!busy_q & (pr_q | pt_q | (|lvl_q)));
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // remote access grant
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rem_gnt_q <= 1'b0;
    end else begin
      rem_gnt_q <= REM_REQ & !busy_q;
    end
  end

  // translation pipeline stage one, entry being read
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      v1_q <= 1'b0;
      off1_q <= 12'h0;
      size1_q <= 2'h0;
      data1_q <= 32'h0;
    end else begin
      v1_q <= DMA_REQ;
      off1_q <= DMA_ADDR[DMAP_PAGE_BITS-1:0];
      size1_q <= DMA_SIZE;
      data1_q <= DMA_DATA;
    end
  end

  // translation pipeline stage two, host beat
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      host_valid_q <= 1'b0;
      host_addr_q <= 32'h0;
      host_data_q <= 32'h0;
      host_tmo_q <= 1'b0;
    end else begin
      host_valid_q <= v1_q;
      host_addr_q <= {mp.rb_data[31:DMAP_PAGE_BITS], off1_q};
      host_tmo_q <= v1_q & mp.rb_data[DMAP_BIT_INVALID];
      if (mp.rb_data[DMAP_BIT_SWAP]) begin
        host_data_q <= swap_beat(data1_q, size1_q);
      end else begin
        host_data_q <= data1_q;
      end
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign DMA_START = busy_q;
  assign HOST_VALID = host_valid_q;
  assign HOST_ADDR = host_addr_q;
  assign HOST_DATA = host_data_q;
  assign HOST_TIMEOUT = host_tmo_q;
  assign REM_GNT = rem_gnt_q;
  assign IRQ = irq_q;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!rst_n);

  sequence done_raised_s;
    busy_q && DMA_FIN ##1 done_q;
  endsequence

  sequence ack_write_s;
    wr_fin && PADDR == DMAP_OFS_DMA_CMD && !PWDATA[DMAP_BIT_DONE]
      && !(busy_q && DMA_FIN);
  endsequence

  sequence beat_in_s;
    DMA_REQ ##2 HOST_VALID;
  endsequence

  done_irq_a: assert property (
    done_raised_s ##0 (done_ien_q && norm_en_q) |=> IRQ)
    else $error("done interrupt not raised");

  done_set_a: assert property (
    busy_q && DMA_FIN |=> done_q && !busy_q && !DMA_START)
    else $error("done bit not set at end of dma");

  done_ack_a: assert property (
    ack_write_s |=> !done_q)
    else $error("done bit not cleared by write of zero");

  irq_gate_a: assert property (
    !norm_en_q && !(err_en_q && err_q != 4'h0) |=> !IRQ)
    else $error("interrupt without enable");

  err_clear_a: assert property (
    wr_fin && PADDR == DMAP_OFS_LOC_CMD && PWDATA[DMAP_BIT_CLR_ERR]
      && ERR_EV == 4'h0 |=> err_q == 4'h0)
    else $error("error bits not cleared");

  pr_clear_a: assert property (
    wr_fin && PADDR == DMAP_OFS_LOC_CMD && PWDATA[DMAP_BIT_CLR_IRQ]
      && !(PR_EV && !busy_q) |=> !pr_q)
    else $error("receiver irq not cleared");

  pt_clear_a: assert property (
    wr_fin && PADDR == DMAP_OFS_REM_CMD1 && PWDATA[DMAP_BIT_CLR_IRQ]
      && !(PT_EV && !busy_q) |=> !pt_q)
    else $error("transmitter irq not cleared");

  grant_block_a: assert property (
    busy_q |=> !REM_GNT)
    else $error("remote access granted during dma");

  fwd_block_a: assert property (
    busy_q && !pr_q && !(wr_fin && PADDR == DMAP_OFS_DMA_CMD) |=> !pr_q)
    else $error("receiver irq passed during dma");

  map_addr_a: assert property (
    beat_in_s |-> HOST_ADDR[11:0] == $past(DMA_ADDR[11:0], 2))
    else $error("page offset not kept");

  map_tmo_a: assert property (
    HOST_TIMEOUT |-> HOST_VALID && $past(mp.rb_data[0], 1))
    else $error("timeout without invalid entry");

  active_bit_a: assert property (
    acc && !pready_q && !map_pend_q && PADDR == DMAP_OFS_IRQ_CTRL
      && !PWRITE |=> PRDATA[7] == $past(IRQ, 1))
    else $error("active bit does not follow interrupt");
endmodule

// ==== rtl/dmap_pkg.sv ====
// constants, offsets and field positions of the dma map and irq service block
package dmap_pkg;
  localparam int DMAP_AW = 16;
  localparam int DMAP_IDXW = 12;
  localparam logic [15:0] DMAP_OFS_IRQ_CTRL = 16'h0000;
  localparam logic [15:0] DMAP_OFS_LOC_STAT = 16'h0004;
  localparam logic [15:0] DMAP_OFS_LOC_CMD = 16'h0008;
  localparam logic [15:0] DMAP_OFS_DMA_CMD = 16'h000c;
  localparam logic [15:0] DMAP_OFS_REM_STAT = 16'h0010;
  localparam logic [15:0] DMAP_OFS_REM_CMD1 = 16'h0014;
  localparam logic [15:0] DMAP_OFS_LVL_STAT = 16'h0018;
  localparam logic [15:0] DMAP_OFS_MAP_BASE = 16'hc000;
  localparam int DMAP_BIT_ACTIVE = 7;
  localparam int DMAP_BIT_NORM_EN = 6;
  localparam int DMAP_BIT_ERR_EN = 5;
  localparam int DMAP_BIT_PR = 5;
  localparam int DMAP_BIT_CLR_ERR = 7;
  localparam int DMAP_BIT_CLR_IRQ = 6;
  localparam int DMAP_BIT_START = 0;
  localparam int DMAP_BIT_DONE = 1;
  localparam int DMAP_BIT_DONE_IEN = 2;
  localparam int DMAP_BIT_PT = 1;
  localparam int DMAP_BIT_INVALID = 0;
  localparam int DMAP_BIT_SWAP = 1;
  localparam int DMAP_PAGE_BITS = 12;
  localparam logic [31:0] DMAP_MAP_KEEP = 32'hffff_f003;
  localparam logic [3:0] DMAP_ERR_RST = 4'h0;
  localparam logic [7:1] DMAP_LVL_RST = 7'h00;
  localparam logic [1:0] DMAP_SZ_BYTE = 2'h0;
  localparam logic [1:0] DMAP_SZ_WORD = 2'h1;
endpackage

// ==== rtl/dmap_map_if.sv ====
// ports of the mapping entry store
`timescale 1ns/100ps
interface dmap_map_if;
  logic we;
  logic [11:0] waddr;
  logic [31:0] wdata;
  logic [11:0] ra_addr;
  logic [31:0] ra_data;
  logic [11:0] rb_addr;
  logic [31:0] rb_data;
  modport mem (
    input we,
    input waddr,
    input wdata,
    input ra_addr,
    input rb_addr,
    output ra_data,
    output rb_data
  );
  modport user (
    output we,
    output waddr,
    output wdata,
    output ra_addr,
    output rb_addr,
    input ra_data,
    input rb_data
  );
endinterface

// ==== rtl/dmap_map_ram.sv ====
// mapping entry store: one write port, two registered read ports
`timescale 1ns/100ps
module dmap_map_ram
  import dmap_pkg::*;
(
  input wire logic clk,
  dmap_map_if.mem mp
);
  logic [31:0] mem_q [0:4095];

  always_ff @(posedge clk) begin
    if (mp.we) begin
      mem_q[mp.waddr] <= mp.wdata & DMAP_MAP_KEEP;
    end
    mp.ra_data <= mem_q[mp.ra_addr];
    mp.rb_data <= mem_q[mp.rb_addr];
  end
endmodule

// ==== verification/dmap_engine_model.sv ====
// transfer engine model: ends a started dma and issues beats
`timescale 1ns/100ps
module dmap_engine_model (
  input wire logic clk,
  input wire logic dma_start,
  input wire logic [7:0] fin_dly,
  output logic fin,
  output logic req,
  output logic [23:0] addr,
  output logic [1:0] size,
  output logic [31:0] data
);
  logic [7:0] cnt_q = 8'h00;
  initial begin
    req = 1'b0;
    addr = 24'h000000;
    size = 2'h0;
    data = 32'h00000000;
  end
  // one end pulse, fin_dly cycles into the run
  always @(posedge clk) begin
    if (!dma_start) begin
      fin <= 1'b0;
      cnt_q <= 8'h00;
    end else if (cnt_q <= fin_dly) begin
      fin <= (cnt_q == fin_dly);
      cnt_q <= cnt_q + 8'h01;
    end else begin
      fin <= 1'b0;
    end
  end
  // one beat; released lines show the inverse of the last value
  task automatic beat(input logic [23:0] a, input logic [1:0] s,
                      input logic [31:0] d);
    @(posedge clk);
    req <= 1'b1;
    addr <= a;
    size <= s;
    data <= d;
    @(posedge clk);
    req <= 1'b0;
    addr <= ~a;
    size <= ~s;
    data <= ~d;
  endtask
endmodule

// ==== verification/dma_pci_map_and_irq_service_tb.sv ====
// self-checking bench for the dma map and irq service block
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
  $display("Error at %0t: got %h exp %h", $time, (a), (b)); end end
module dma_pci_map_and_irq_service_tb;
  import dmap_pkg::*;
  logic CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0;
  logic PWRITE = 1'b0, PR_EV = 1'b0, PT_EV = 1'b0, REM_REQ = 1'b0;
  logic [15:0] PADDR = 16'h0000;
  logic [31:0] PWDATA = 32'h0, PRDATA, DMA_DATA, HOST_ADDR, HOST_DATA;
  logic PREADY, PSLVERR, DMA_START, DMA_FIN, DMA_REQ, HOST_VALID;
  logic HOST_TIMEOUT, REM_GNT, IRQ, serr;
  logic [23:0] DMA_ADDR;
  logic [1:0] DMA_SIZE;
  logic [3:0] ERR_EV = 4'h0;
  logic [7:1] IRQ_LVL = 7'h00;
  logic [7:0] fin_dly = 8'h20;
  logic [31:0] rdat;
  int mismatches = 0, n_tests = 0, cyc = 0;
  always #5 CLK = ~CLK;
  dmap_top dmap_top_inst (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .DMA_START(DMA_START), .DMA_FIN(DMA_FIN), .DMA_REQ(DMA_REQ),
    .DMA_ADDR(DMA_ADDR), .DMA_SIZE(DMA_SIZE), .DMA_DATA(DMA_DATA),
    .HOST_VALID(HOST_VALID), .HOST_ADDR(HOST_ADDR), .HOST_DATA(HOST_DATA),
    .HOST_TIMEOUT(HOST_TIMEOUT), .ERR_EV(ERR_EV), .PR_EV(PR_EV),
    .PT_EV(PT_EV), .IRQ_LVL(IRQ_LVL), .REM_REQ(REM_REQ),
    .REM_GNT(REM_GNT), .IRQ(IRQ));
  dmap_engine_model dmap_engine_model_inst (.clk(CLK),
    .dma_start(DMA_START), .fin_dly(fin_dly), .fin(DMA_FIN),
    .req(DMA_REQ), .addr(DMA_ADDR), .size(DMA_SIZE), .data(DMA_DATA));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic apb(input logic wr, input logic [15:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    rdat = PRDATA;
    serr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    `CHK(PREADY, 1'b1)
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdat, e)
  endtask
  task automatic pulse_ev(input logic [3:0] e, input logic p, input logic t);
    @(posedge CLK);
    ERR_EV <= e;
    PR_EV <= p;
    PT_EV <= t;
    @(posedge CLK);
    ERR_EV <= 4'h0;
    PR_EV <= 1'b0;
    PT_EV <= 1'b0;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (2) @(posedge CLK);
    while (DMA_START !== 1'b0 && n < 100) begin
      @(posedge CLK);
      n++;
    end
    `CHK(DMA_START, 1'b0)
    repeat (3) @(posedge CLK);
  endtask
  function automatic logic [31:0] swp(input logic [31:0] d,
                                      input logic [1:0] s, input logic en);
    if (!en || s == 2'h0) return d;
    if (s == 2'h1) return {d[23:16], d[31:24], d[7:0], d[15:8]};
    return {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction
  task automatic t_map();
    wr(DMAP_OFS_MAP_BASE, 32'h0100_0000);
    wr(16'hc00c, 32'h0100_3002);
    wr(16'hfffc, 32'habcd_effd);
    rd_chk(DMAP_OFS_MAP_BASE, 32'h0100_0000);
    rd_chk(16'hc00c, 32'h0100_3002);
    rd_chk(16'hfffc, 32'habcd_e001);
    apb(1'b0, 16'h0100, 32'h0);
    `CHK(serr, 1'b1)
    `CHK(rdat, 32'h0)
  endtask
  task automatic t_xlate();
    logic [11:0] ix, of;
    logic [31:0] ent, d;
    int n;
    for (int i = 0; i < 4; i++) begin
      ix = (i == 3) ? 12'hfff : 12'h003;
      ent = (i == 3) ? 32'habcd_effd : 32'h0100_3002;
      of = 12'h5a0 + 12'(i);
      d = 32'h1122_3344 + 32'(i);
      dmap_engine_model_inst.beat({ix, of}, 2'(i), d);
      n = 0;
      #1;
      while (HOST_VALID !== 1'b1 && n < 6) begin
        @(posedge CLK);
        #1;
        n++;
      end
      `CHK(HOST_VALID, 1'b1)
      `CHK(HOST_ADDR, {ent[31:12], of})
      `CHK(HOST_DATA, swp(d, 2'(i), ent[1]))
      `CHK(HOST_TIMEOUT, ent[0])
    end
  endtask
  task automatic t_dma();
    wr(DMAP_OFS_IRQ_CTRL, 32'h40);
    wr(DMAP_OFS_DMA_CMD, 32'h4);
    wr(DMAP_OFS_DMA_CMD, 32'h5);
    REM_REQ <= 1'b1;
    pulse_ev(4'h0, 1'b1, 1'b0);
    repeat (3) @(posedge CLK);
    `CHK(DMA_START, 1'b1)
    `CHK(REM_GNT, 1'b0)
    `CHK(IRQ, 1'b0)
    wait_idle();
    `CHK(IRQ, 1'b1)
    `CHK(REM_GNT, 1'b1)
    REM_REQ <= 1'b0;
    rd_chk(DMAP_OFS_DMA_CMD, 32'h6);
    rd_chk(DMAP_OFS_IRQ_CTRL, 32'hc0);
    rd_chk(DMAP_OFS_LOC_STAT, 32'h0);
    wr(DMAP_OFS_DMA_CMD, 32'h4);
    repeat (2) @(posedge CLK);
    `CHK(IRQ, 1'b0)
    rd_chk(DMAP_OFS_DMA_CMD, 32'h4);
    wr(DMAP_OFS_IRQ_CTRL, 32'h0);
    fin_dly <= 8'h00;
    wr(DMAP_OFS_DMA_CMD, 32'h5);
    wait_idle();
    `CHK(IRQ, 1'b0)
    rd_chk(DMAP_OFS_DMA_CMD, 32'h6);
    wr(DMAP_OFS_DMA_CMD, 32'h0);
    wr(DMAP_OFS_IRQ_CTRL, 32'h40);
    wr(DMAP_OFS_DMA_CMD, 32'h1);
    wait_idle();
    `CHK(IRQ, 1'b0)
    rd_chk(DMAP_OFS_DMA_CMD, 32'h2);
    wr(DMAP_OFS_DMA_CMD, 32'h0);
  endtask
  task automatic t_events();
    logic [3:0] m;
    wr(DMAP_OFS_IRQ_CTRL, 32'h60);
    for (int i = 0; i < 5; i++) begin
      m = (i == 4) ? 4'hf : 4'(1 << i);
      pulse_ev(m, 1'b0, 1'b0);
      repeat (2) @(posedge CLK);
      `CHK(IRQ, 1'b1)
      rd_chk(DMAP_OFS_IRQ_CTRL, 32'he0);
      rd_chk(DMAP_OFS_LOC_STAT, {28'h0, m});
      wr(DMAP_OFS_LOC_CMD, 32'h80);
      if (i == 1) apb(1'b0, DMAP_OFS_REM_STAT, 32'h0);
      rd_chk(DMAP_OFS_LOC_STAT, 32'h0);
      `CHK(IRQ, 1'b0)
    end
    pulse_ev(4'h0, 1'b1, 1'b0);
    rd_chk(DMAP_OFS_LOC_STAT, 32'h20);
    wr(DMAP_OFS_LOC_CMD, 32'h40);
    rd_chk(DMAP_OFS_LOC_STAT, 32'h0);
    pulse_ev(4'h0, 1'b0, 1'b1);
    rd_chk(DMAP_OFS_REM_STAT, 32'h2);
    wr(DMAP_OFS_REM_CMD1, 32'h40);
    rd_chk(DMAP_OFS_REM_STAT, 32'h0);
    IRQ_LVL <= 7'h48;
    repeat (4) @(posedge CLK);
    rd_chk(DMAP_OFS_LVL_STAT, 32'h90);
    `CHK(IRQ, 1'b1)
    IRQ_LVL <= 7'h00;
    repeat (4) @(posedge CLK);
    rd_chk(DMAP_OFS_LVL_STAT, 32'h0);
  endtask
  initial begin
    repeat (5) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    t_map();
    t_xlate();
    t_dma();
    t_events();
    report_and_stop();
  end
endmodule
